// ---- rtl/vme_irq_handler_regs.vh ----
// Register offsets, field positions and codes for the VME interrupt handler
`ifndef VME_IRQ_HANDLER_REGS_VH
`define VME_IRQ_HANDLER_REGS_VH

// Register offsets (byte addresses on the plain register port)
`define OFS_SUMMARY     8'h00
`define OFS_CONFIG      8'h04
`define OFS_LEVEL_MAP   8'h08
`define OFS_VEC_OFFSET  8'h0c
`define OFS_ERR_INFO    8'h10
`define OFS_LAST_VECTOR 8'h14

// Summary register fields
`define SUM_SENT_LSB    0
`define SUM_SENT_MSB    3
`define SUM_PEND_LSB    4
`define SUM_PEND_MSB    10
`define SUM_ME_BIT      14
`define SUM_ERR_LSB     16
`define SUM_ERR_MSB     21

// Configuration register fields
`define CFG_ERR_DIS_BIT 17
`define CFG_EN_LSB      18
`define CFG_EN_MSB      24
`define CFG_MASK_LSB    25
`define CFG_MASK_MSB    31
`define CFG_ERR_LVL_LSB 12
`define CFG_ERR_LVL_MSB 13

// Vector offset field
`define VOF_LSB         8
`define VOF_MSB         15

// Reset values
`define CONFIG_RST      32'hfe000000
`define LEVEL_MAP_RST   14'h0e4f
`define VEC_OFFSET_RST  8'h00

// Number of error sources
`define ERR_COUNT       6

`endif

// ---- rtl/err_capture.v ----
// Error status, first-error capture lock and multiple-error flag
`timescale 1ns/1ns
module err_capture (
  input  wire        core_clk,   // System clock
  input  wire        rst,        // Synchronous reset, active high
  input  wire [5:0]  err_event,  // One-cycle error events
  input  wire [31:0] err_info,   // Information to capture with an error
  input  wire [5:0]  err_clr,    // Write-one-to-clear of error bits
  input  wire        me_clr,     // Write-one-to-clear of multiple error
  output reg  [5:0]  err_q,      // Sticky error status
  output reg         multiple_error_flag, // Second error while locked
  output reg  [31:0] info_q      // Captured information of first error
);

  wire locked;
  wire any_event;

  assign locked    = |err_q;
  assign any_event = |err_event;

  // Sticky error bits; a new event wins over a clear in the same cycle
  always @(posedge core_clk) begin
    if (rst) begin
      err_q <= 6'h00;
    end else begin
      err_q <= (err_q & ~err_clr) | err_event;
    end
  end

  // Capture only while unlocked, so the first error's data is kept
  always @(posedge core_clk) begin
    if (rst) begin
      info_q <= 32'h00000000;
    end else if (any_event && !locked) begin
      info_q <= err_info;
    end
  end

  // Another error before the earlier bit is cleared marks a multiple error
  always @(posedge core_clk) begin
    if (rst) begin
      multiple_error_flag <= 1'b0;
    end else if (any_event && locked) begin
      multiple_error_flag <= 1'b1;
    end else if (me_clr) begin
      multiple_error_flag <= 1'b0;
    end
  end

endmodule // err_capture

// ---- rtl/vme_irq_handler.v ----
// VME interrupt handler: pending levels, host forwarding, IACK cycle
//
// Summary of operation
// - Level seven has the highest priority among pending requests.
// - Pending bit 10:4 sets as soon as a level's request line asserts.
// - Forward only when that level's enable and mask bits are both clear.
// - Win VME arbitration before servicing an interrupt request.
// - Issuing a forwarded host interrupt command sets the sent bit in 3:0.
// - Host command is placed at the host level mapped to the request.
// - The identify command clears the sent field 3:0.
// - Assert interrupt acknowledge and drive the level on A01 to A03.
// - Issuing the acknowledge clears that level's pending bit.
// - Run 32-bit acknowledge cycles, capture only the low status byte.
// - Vector is status/ID joined to offset bits 15:8, sent on identify.
// - Drop the two low status/ID bits, giving a longword-aligned vector.
// - With interrupts enabled, listed bus errors interrupt the host.
// - Read errors use the plain command, write errors the implied one.
// - An error freezes capture registers until every error status bit clears.
// - A second error while locked sets bit 14; first data kept.
// - Never drive interrupt requests onto the VMEbus.
// - A granted requester asserts bus busy and owns the bus until release.
// - Pass the bus grant on when no request is pending at that level.
// - On bus clear the master may finish its transfer before releasing; bclr_n is ignored.
`timescale 1ns/1ns
`include "vme_irq_handler_regs.vh"
module vme_irq_handler (
  input  wire        core_clk,       // System clock, 250 MHz
  input  wire        rst,            // Synchronous reset, active high
  // Register port
  input  wire [7:0]  reg_addr,       // Byte address
  input  wire [31:0] reg_wdata,      // Write data
  input  wire        reg_wr,         // Write strobe
  input  wire        reg_rd,         // Read strobe
  output reg  [31:0] reg_rdata_q,    // Read data, cycle after the strobe
  // VME priority interrupt bus
  input  wire [7:1]  irq_n,          // Request lines, active low
  output reg         iack_n_q,       // Interrupt acknowledge, active low
  output reg  [3:1]  vme_addr_q,     // Level on A01 to A03
  output reg         as_n_q,         // Address strobe, active low
  output reg         ds0_n_q,        // Data strobe zero, active low
  output reg         ds1_n_q,        // Data strobe one, active low
  output reg         lword_n_q,      // Longword select, active low
  output reg         write_n_q,      // Direction, high for read
  output reg         dtb_oe_q,       // Drive enable for strobes and address
  input  wire [7:0]  vme_data,       // D0 to D07 status/ID
  input  wire        dtack_n,        // Data acknowledge, active low
  input  wire        berr_n,         // Bus error, active low
  // VME arbitration bus
  output wire        br_out,         // Bus request pin value, always low
  output reg         br_oe_q,        // Bus request driven while requesting
  input  wire        bgin_n,         // Bus grant in, active low
  output wire        bgout_n,        // Bus grant out, active low
  input  wire        bbsy_in_n,      // Bus busy as seen on the wire
  output wire        bbsy_out,       // Bus busy pin value, always low
  output reg         bbsy_oe_q,      // Bus busy driven while owning bus
  input  wire        bclr_n,         // Bus clear, active low
  // Host side
  output reg         host_interrupt_cmd,          // Interrupt command pulse
  output reg         implied_vector_interrupt_cmd, // Implied vector pulse
  output reg  [1:0]  host_request_level,          // Level of the command
  input  wire        ident_cmd,      // Identify command pulse
  output reg         vector_valid_q, // Vector answer pulse
  output reg  [15:0] vector_q,       // Longword-aligned vector
  // Error sources
  input  wire [5:0]  err_event,      // Reset, timeout, arb, RMW, lock, par
  input  wire        err_is_write,   // Error came from a write transaction
  input  wire [31:0] err_info        // Information captured with an error
);

  // Handler sequence states
  localparam S_IDLE  = 3'd0;
  localparam S_ARB   = 3'd1;
  localparam S_SEND  = 3'd2;
  localparam S_WAIT  = 3'd3;
  localparam S_IACK  = 3'd4;
  localparam S_DONE  = 3'd5;

  reg  [2:0]  state_q;
  reg  [2:0]  level_q;       // Level under service
  reg  [7:1]  pend_q;        // Pending request levels
  reg  [7:1]  irq_prev_q;    // Request lines seen last cycle
  reg  [3:0]  sent_q;        // Sent bits per host request level
  reg  [31:0] config_q;      // Enables, masks, error level
  reg  [13:0] map_q;         // Two bits of host level per VME level
  reg  [7:0]  vec_ofs_q;     // Vector offset
  reg  [15:0] last_vec_q;    // Last vector formed
  reg  [7:0]  status_id_q;   // Captured status/ID byte
  reg         err_pend_q;    // Error command waiting for the host port
  reg         err_wr_q;      // Waiting error came from a write
  wire [7:1]  eligible;
  wire [2:0]  best;
  wire [5:0]  err_q;
  wire        multiple_error_flag;
  wire [31:0] info_q;
  wire        wr_sum;
  wire [5:0]  err_clr;
  wire        me_clr;
  wire        err_en;
  wire        err_hit;
  reg  [31:0] rd_mux;

  // Highest pending level wins; level seven first
  function [2:0] top_level;
    input [7:1] req;
    integer i;
    begin
      top_level = 3'd0;
      for (i = 1; i <= 7; i = i + 1) begin
        if (req[i]) begin
          top_level = i[2:0];
        end
      end
    end
  endfunction

  // Host request level assigned to a VME level
  function [1:0] map_level;
    input [13:0] map;
    input [2:0]  lvl;
    begin
      case (lvl)
        3'd1:    map_level = map[1:0];
        3'd2:    map_level = map[3:2];
        3'd3:    map_level = map[5:4];
        3'd4:    map_level = map[7:6];
        3'd5:    map_level = map[9:8];
        3'd6:    map_level = map[11:10];
        3'd7:    map_level = map[13:12];
        default: map_level = 2'd0;
      endcase
    end
  endfunction

  // A level is forwarded only with its enable and mask bits both clear
  assign eligible = pend_q
                  & ~config_q[`CFG_EN_MSB:`CFG_EN_LSB]
                  & ~config_q[`CFG_MASK_MSB:`CFG_MASK_LSB];
  assign best = top_level(eligible);

  // Open-collector arbitration pins only ever pull low
  assign br_out   = 1'b0;
  assign bbsy_out = 1'b0;
  // Grant is passed on unless our own request is waiting for it
  assign bgout_n = (state_q == S_ARB) ? 1'b1 : bgin_n;

  // Register writes to the summary register clear error and multiple-error bits
  assign wr_sum  = reg_wr && (reg_addr == `OFS_SUMMARY);
  assign err_clr = wr_sum ? reg_wdata[`SUM_ERR_MSB:`SUM_ERR_LSB] : 6'h00;
  assign me_clr  = wr_sum && reg_wdata[`SUM_ME_BIT];
  assign err_en  = !config_q[`CFG_ERR_DIS_BIT];
  assign err_hit = |err_event;

  err_capture u_err_capture (
    .core_clk            (core_clk),
    .rst                 (rst),
    .err_event           (err_event),
    .err_info            (err_info),
    .err_clr             (err_clr),
    .me_clr              (me_clr),
    .err_q               (err_q),
    .multiple_error_flag (multiple_error_flag),
    .info_q              (info_q)
  );

  // Software-written configuration steers forwarding and vector forming
  always @(posedge core_clk) begin
    if (rst) begin
      config_q  <= `CONFIG_RST;
      map_q     <= `LEVEL_MAP_RST;
      vec_ofs_q <= `VEC_OFFSET_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_CONFIG:     config_q  <= reg_wdata;
        `OFS_LEVEL_MAP:  map_q     <= reg_wdata[13:0];
        `OFS_VEC_OFFSET: vec_ofs_q <= reg_wdata[`VOF_MSB:`VOF_LSB];
        default:         config_q  <= config_q;
      endcase
    end
  end

  // Pending bits set on a new assertion; the set wins over the ack clear.
  // Edge detection keeps a still-low line from re-arming after its ack.
  always @(posedge core_clk) begin
    if (rst) begin
      pend_q     <= 7'h00;
      irq_prev_q <= 7'h00;
    end else begin
      irq_prev_q <= ~irq_n;
      pend_q     <= (pend_q
                    & ~((state_q == S_WAIT && ident_cmd)
                        ? (7'h01 << (level_q - 3'd1)) : 7'h00))
                    | (~irq_n & ~irq_prev_q);
    end
  end

  // Sent bits: set on a forwarded command, cleared by identify
  always @(posedge core_clk) begin
    if (rst) begin
      sent_q <= 4'h0;
    end else if (state_q == S_SEND) begin
      sent_q <= sent_q | (4'h1 << map_level(map_q, level_q));
    end else if (ident_cmd) begin
      sent_q <= 4'h0;
    end
  end

  // Main handler sequence. The bus is held across the host round trip;
  // bclr_n is not used; the bus is released only when the acknowledge cycle is complete.
  always @(posedge core_clk) begin
    if (rst) begin
      state_q        <= S_IDLE;
      level_q        <= 3'd0;
      br_oe_q        <= 1'b0;
      bbsy_oe_q      <= 1'b0;
      iack_n_q       <= 1'b1;
      as_n_q         <= 1'b1;
      ds0_n_q        <= 1'b1;
      ds1_n_q        <= 1'b1;
      lword_n_q      <= 1'b1;
      write_n_q      <= 1'b1;
      dtb_oe_q       <= 1'b0;
      vme_addr_q     <= 3'd0;
      status_id_q    <= 8'h00;
      vector_valid_q <= 1'b0;
      vector_q       <= 16'h0000;
      last_vec_q     <= 16'h0000;
    end else begin
      vector_valid_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (best != 3'd0) begin
            level_q <= best;
            br_oe_q <= 1'b1;
            state_q <= S_ARB;
          end
        end
        S_ARB: begin
          // Own the bus only once granted and the wire is free
          if (!bgin_n && bbsy_in_n) begin
            br_oe_q   <= 1'b0;
            bbsy_oe_q <= 1'b1;
            state_q   <= S_SEND;
          end
        end
        S_SEND: begin
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (ident_cmd) begin
            // 32-bit read acknowledge cycle at the serviced level
            iack_n_q   <= 1'b0;
            vme_addr_q <= level_q;
            as_n_q     <= 1'b0;
            ds0_n_q    <= 1'b0;
            ds1_n_q    <= 1'b0;
            lword_n_q  <= 1'b0;
            write_n_q  <= 1'b1;
            dtb_oe_q   <= 1'b1;
            state_q    <= S_IACK;
          end
        end
        S_IACK: begin
          // Interrupter answers with DTACK and its status/ID
          if (!dtack_n || !berr_n) begin
            status_id_q <= dtack_n ? 8'h00 : vme_data;
            iack_n_q    <= 1'b1;
            as_n_q      <= 1'b1;
            ds0_n_q     <= 1'b1;
            ds1_n_q     <= 1'b1;
            lword_n_q   <= 1'b1;
            state_q     <= S_DONE;
          end
        end
        S_DONE: begin
          // Low two status bits dropped for longword alignment
          vector_q <= {vec_ofs_q, status_id_q[7:2], 2'b00};
          last_vec_q <= {vec_ofs_q, status_id_q[7:2], 2'b00};
          vector_valid_q <= 1'b1;
          dtb_oe_q       <= 1'b0;
          bbsy_oe_q      <= 1'b0;
          state_q        <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Error command waits here if the host port is busy with a request
  always @(posedge core_clk) begin
    if (rst) begin
      err_pend_q <= 1'b0;
      err_wr_q   <= 1'b0;
    end else if (err_hit && err_en) begin
      err_pend_q <= 1'b1;
      err_wr_q   <= err_is_write;
    end else if (state_q != S_SEND) begin
      err_pend_q <= 1'b0;
    end
  end

  // Host command outputs; the forwarded request has the port first
  always @(posedge core_clk) begin
    if (rst) begin
      host_interrupt_cmd           <= 1'b0;
      implied_vector_interrupt_cmd <= 1'b0;
      host_request_level           <= 2'd0;
    end else if (state_q == S_SEND) begin
      host_interrupt_cmd           <= 1'b1;
      implied_vector_interrupt_cmd <= 1'b0;
      host_request_level <= map_level(map_q, level_q);
    end else if (err_pend_q) begin
      host_interrupt_cmd           <= !err_wr_q;
      implied_vector_interrupt_cmd <= err_wr_q;
      host_request_level <= config_q[`CFG_ERR_LVL_MSB:`CFG_ERR_LVL_LSB];
    end else begin
      host_interrupt_cmd           <= 1'b0;
      implied_vector_interrupt_cmd <= 1'b0;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `OFS_SUMMARY: begin
        rd_mux[`SUM_SENT_MSB:`SUM_SENT_LSB] = sent_q;
        rd_mux[`SUM_PEND_MSB:`SUM_PEND_LSB] = pend_q;
        rd_mux[`SUM_ME_BIT]                 = multiple_error_flag;
        rd_mux[`SUM_ERR_MSB:`SUM_ERR_LSB]   = err_q;
      end
      `OFS_CONFIG:      rd_mux = config_q;
      `OFS_LEVEL_MAP:   rd_mux[13:0] = map_q;
      `OFS_VEC_OFFSET:  rd_mux[`VOF_MSB:`VOF_LSB] = vec_ofs_q;
      `OFS_ERR_INFO:    rd_mux = info_q;
      `OFS_LAST_VECTOR: rd_mux[15:0] = last_vec_q;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the read strobe
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end

  // No request line is ever driven by this block: irq_n is input only

endmodule // vme_irq_handler

// ---- dv/vme_irq_handler_assertions.sv ----
// Port-level checks of the VME interrupt handler
`timescale 1ns/1ns
module vme_irq_handler_assertions (
  input wire        core_clk,       // System clock
  input wire        rst,            // Synchronous reset
  input wire        iack_n_q,       // Interrupt acknowledge
  input wire        as_n_q,         // Address strobe
  input wire        ds0_n_q,        // Data strobe zero
  input wire        ds1_n_q,        // Data strobe one
  input wire        lword_n_q,      // Longword select
  input wire        write_n_q,      // Direction
  input wire [3:1]  vme_addr_q,     // Level on A01 to A03
  input wire [7:0]  vme_data,       // Status/ID lines
  input wire        dtack_n,        // Data acknowledge
  input wire        br_oe_q,        // Bus request drive
  input wire        bgin_n,         // Grant in
  input wire        bgout_n,        // Grant out
  input wire        bbsy_oe_q,      // Bus busy drive
  input wire        vector_valid_q, // Vector pulse
  input wire [15:0] vector_q,       // Vector
  input wire        dtb_oe_q        // Strobe and address drive enable
);
  // Upper six status bits, the only ones that reach the vector
  wire [5:0] stat_hi = vme_data[7:2];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_IACK_D32: assert property (!iack_n_q && !as_n_q |-> write_n_q &&
    !lword_n_q && !ds0_n_q && !ds1_n_q && vme_addr_q != 3'h0)
    else $error("acknowledge cycle is not a 32-bit read of a level");
  AST_IACK_OWNS: assert property (!iack_n_q |-> bbsy_oe_q)
    else $error("acknowledge without owning the bus");
  AST_GRANT_FIRST: assert property ($rose(bbsy_oe_q) |->
    !$past(bgin_n) && !br_oe_q)
    else $error("bus busy taken without a grant");
  AST_GRANT_PASS: assert property (
    bgout_n == (br_oe_q ? 1'b1 : bgin_n))
    else $error("grant chain not passed or not held");
  AST_BBSY_TILL_VEC: assert property ($fell(bbsy_oe_q) |-> vector_valid_q)
    else $error("bus released before the acknowledge ended");
  AST_VEC_ALIGN: assert property (vector_valid_q |->
    vector_q[1:0] == 2'h0)
    else $error("vector not longword aligned");
  AST_VEC_STATUS: assert property (vector_valid_q && !$past(dtack_n, 2) |->
    vector_q[7:2] == $past(stat_hi, 2))
    else $error("vector does not carry the status byte");
  AST_STROBE_REL: assert property (!dtack_n && !as_n_q && !iack_n_q |=>
    as_n_q && ds0_n_q && ds1_n_q)
    else $error("strobes not released after data acknowledge");
  // An undriven strobe would float while the level is being acknowledged
  AST_DTB_DRIVE: assert property (!as_n_q |-> dtb_oe_q)
    else $error("address strobe asserted without driving the bus");
endmodule // vme_irq_handler_assertions

// ---- dv/vme_far_end.sv ----
// Far side of the handler: interrupters, grant chain and bus busy wire
`timescale 1ns/1ns
module vme_far_end (
  input  wire       core_clk,    // System clock
  input  wire       rst,         // Synchronous reset, active high
  input  wire [7:1] raise,       // One-cycle pulse per level to request
  input  wire [7:0] status_base, // Status/ID base, level added on
  input  wire [3:0] ack_wait,    // Cycles before the data acknowledge
  input  wire       iack_n_q,    // Interrupt acknowledge from handler
  input  wire       as_n_q,      // Address strobe from handler
  input  wire [3:1] vme_addr_q,  // Level on A01 to A03
  input  wire       br_oe_q,     // Handler requests the bus
  input  wire       bbsy_oe_q,   // Handler drives bus busy
  output wire [7:1] irq_n,       // Request lines
  output reg        bgin_n,      // Grant into the handler
  output wire       bbsy_in_n,   // Bus busy wire level
  output wire       dtack_n,     // Data acknowledge
  output reg  [7:0] vme_data     // Status/ID lines
);
  reg [7:1] req_q;
  reg [3:0] cnt_q;
  reg       ack_q;
  // Only the interrupter whose level matches answers
  wire sel = !iack_n_q && !as_n_q &&
             (ack_q || (vme_addr_q != 3'h0 && req_q[vme_addr_q]));

  assign irq_n     = ~req_q;     // One line per requesting level
  assign bbsy_in_n = ~bbsy_oe_q; // Pull-up frees the wire when released
  assign dtack_n   = ~ack_q;

  // Arbiter grants a free bus only, and only while asked
  always @(posedge core_clk) begin
    if (rst) begin
      bgin_n <= 1'b1;
    end else begin
      bgin_n <= !(br_oe_q && bbsy_in_n);
    end
  end

  // Release-on-acknowledge interrupters; data lines toggle when not driven
  always @(posedge core_clk) begin
    if (rst) begin
      req_q    <= 7'h00;
      cnt_q    <= 4'h0;
      ack_q    <= 1'b0;
      vme_data <= 8'h00;
    end else if (!sel) begin
      req_q    <= req_q | raise;
      cnt_q    <= 4'h0;
      ack_q    <= 1'b0;
      vme_data <= ~vme_data;
    end else if (ack_q) begin
      cnt_q <= cnt_q;
    end else if (cnt_q == ack_wait) begin
      ack_q             <= 1'b1;
      req_q[vme_addr_q] <= 1'b0;
      vme_data          <= status_base + {5'h00, vme_addr_q};
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // vme_far_end

// ---- dv/vme_irq_handler_tb.sv ----
// Self-checking bench for the VME interrupt handler
`timescale 1ns/1ns
module vme_irq_handler_tb;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         ident_cmd = 1'b0;
  reg  [5:0]  err_event = 6'h00;
  reg         err_is_write = 1'b0;
  reg  [31:0] err_info = 32'h0;
  reg  [7:1]  raise = 7'h00;
  reg  [3:0]  ack_wait = 4'h0;
  wire [31:0] reg_rdata_q;
  wire [7:1]  irq_n;
  wire [3:1]  vme_addr_q;
  wire [7:0]  vme_data;
  wire [1:0]  host_request_level;
  wire [15:0] vector_q;
  wire        iack_n_q, as_n_q, ds0_n_q, ds1_n_q, lword_n_q, write_n_q;
  wire        dtack_n, br_oe_q, bgin_n, bgout_n, bbsy_in_n, bbsy_oe_q;
  wire        host_interrupt_cmd, implied_vector_interrupt_cmd;
  wire        vector_valid_q;
  int         num_errors = 0;
  int         n_compared = 0;
  int         n_int = 0;
  int         n_iv = 0;
  int         n_vec = 0;
  reg  [1:0]  lvl_seen;
  reg  [3:1]  ack_lvl;
  reg  [15:0] vec_seen;

  vme_irq_handler dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .irq_n, .iack_n_q, .vme_addr_q, .as_n_q,
    .ds0_n_q, .ds1_n_q, .lword_n_q, .write_n_q, .dtb_oe_q(), .vme_data,
    .dtack_n, .berr_n(1'b1), .br_out(), .br_oe_q, .bgin_n, .bgout_n,
    .bbsy_in_n, .bbsy_out(), .bbsy_oe_q, .bclr_n(1'b1), .host_interrupt_cmd,
    .implied_vector_interrupt_cmd, .host_request_level, .ident_cmd,
    .vector_valid_q, .vector_q, .err_event, .err_is_write, .err_info);
  vme_far_end far_u (.core_clk, .rst, .raise, .status_base(8'h40),
    .ack_wait, .iack_n_q, .as_n_q, .vme_addr_q, .br_oe_q, .bbsy_oe_q,
    .irq_n, .bgin_n, .bbsy_in_n, .dtack_n, .vme_data);

  always #2 core_clk = ~core_clk;

  // Count host commands and vectors, keep the last level and vector
  always @(posedge core_clk) begin
    if (host_interrupt_cmd === 1'b1) begin
      n_int++;
      lvl_seen = host_request_level;
    end
    if (implied_vector_interrupt_cmd === 1'b1) n_iv++;
    if (vector_valid_q === 1'b1) begin
      n_vec++;
      vec_seen = vector_q;
    end
    if (iack_n_q === 1'b0 && as_n_q === 1'b0) ack_lvl = vme_addr_q;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata_q, exp);
  endtask

  // Bounded wait; running out of cycles counts as a mismatch here, so a
  // stale level or vector cannot pass the checks that follow
  task automatic wait_for(input int which, input int target);
    int i;
    int got;
    got = 0;
    for (i = 0; i < 300; i++) begin
      got = which == 0 ? n_int : which == 1 ? n_iv : n_vec;
      if (got >= target) break;
      @(posedge core_clk);
    end
    #1 chk("wait count", got, target);
  endtask

  task automatic ident();
    @(posedge core_clk);
    ident_cmd <= 1'b1;
    @(posedge core_clk);
    ident_cmd <= 1'b0;
  endtask

  task automatic req(input logic [7:1] lv);
    @(posedge core_clk);
    raise <= lv;
    @(posedge core_clk);
    raise <= 7'h00;
  endtask

  task automatic err(input logic [5:0] ev, input logic w,
                     input logic [31:0] info);
    @(posedge core_clk);
    err_event    <= ev;
    err_is_write <= w;
    err_info     <= info;
    @(posedge core_clk);
    err_event <= 6'h00;
  endtask

  task automatic t_reset();
    rd_chk("config", 8'h04, 32'hfe000000);
    rd_chk("map", 8'h08, 32'h00000e4f);
    rd_chk("offset", 8'h0c, 32'h0);
    rd_chk("unmapped", 8'h3c, 32'h0);
    chk("iack idle", iack_n_q, 32'h1);
  endtask

  // Level five waits pending while masked, then while still disabled
  task automatic t_masked();
    req(7'b0010000);
    repeat (3) @(posedge core_clk);
    rd_chk("pending", 8'h00, 32'h00000100);
    wr(8'h04, 32'h00400000);
    repeat (20) @(posedge core_clk);
    chk("blocked", n_int, 32'h0);
  endtask

  // Open levels three, five, six and seven; written map 1e4f sends level five to host level two
  task automatic t_forward();
    wr(8'h0c, 32'h0000a500);
    wr(8'h08, 32'h00001e4f);
    wr(8'h04, 32'h002c0000);
    wait_for(0, 1);
    chk("cmd count", n_int, 32'h1);
    chk("host level", lvl_seen, 32'h2);
    rd_chk("sent and pending", 8'h00, 32'h00000104);
    ident();
    wait_for(2, 1);
    chk("ack level", ack_lvl, 32'h5);
    chk("vector", vec_seen, 32'ha544);
    rd_chk("after ident", 8'h00, 32'h0);
  endtask

  // Levels three and six at once, slow interrupters
  task automatic t_priority();
    @(posedge core_clk);
    ack_wait <= 4'h5;
    req(7'b0100100);
    wait_for(0, 2);
    chk("first level", lvl_seen, 32'h3);
    ident();
    wait_for(2, 2);
    chk("ack six", ack_lvl, 32'h6);
    chk("vector six", vec_seen, 32'ha544);
    wait_for(0, 3);
    chk("second level", lvl_seen, 32'h0);
    ident();
    wait_for(2, 3);
    chk("vector three", vec_seen, 32'ha540);
  endtask

  task automatic t_errors();
    wr(8'h04, 32'h002c3000);
    err(6'h02, 1'b0, 32'h11112222);
    wait_for(0, 4);
    chk("err level", lvl_seen, 32'h3);
    rd_chk("info", 8'h10, 32'h11112222);
    err(6'h10, 1'b1, 32'h33334444);
    wait_for(1, 1);
    chk("implied count", n_iv, 32'h1);
    rd_chk("second error", 8'h00, 32'h00124000);
    rd_chk("info kept", 8'h10, 32'h11112222);
    wr(8'h00, 32'h00124000);
    wr(8'h04, 32'h002e3000);
    err(6'h01, 1'b0, 32'h55556666);
    repeat (10) @(posedge core_clk);
    chk("no cmd when off", n_int, 32'h4);
    rd_chk("status still", 8'h00, 32'h00010000);
    rd_chk("new info", 8'h10, 32'h55556666);
  endtask

  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_masked();
    t_forward();
    t_priority();
    t_errors();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #40000;
    num_errors++;
    test_done();
  end
endmodule // vme_irq_handler_tb

bind vme_irq_handler vme_irq_handler_assertions chk_u (.core_clk, .rst,
  .iack_n_q, .as_n_q, .ds0_n_q, .ds1_n_q, .lword_n_q, .write_n_q,
  .vme_addr_q, .vme_data, .dtack_n, .br_oe_q, .bgin_n, .bgout_n,
  .bbsy_oe_q, .vector_valid_q, .vector_q, .dtb_oe_q);
